// ### hdl/xbh_port.sv
// Expansion bus host port: sync master, async slave and hold arbitration
// Functional notes
// - Ready line is active low during host-port accesses, input or output.
// - As bus master the burst-last output is always active low.
// - Shared byte-enable/address lines carry byte enables in host-port accesses.
// - Write/wait pin is a wait output, updated after bus clock rises.
// - Direction line polarity comes from a strap latched at boot.
// - Arbiter enabled: pending transactions finish before hold grant rises.
// - Arbiter enabled: float bus group at least 3P after hold request.
// - Arbiter enabled: raise grant within 2P after the group floats.
// - Arbiter enabled: keep grant 3P after request drops, then lower.
// - Arbiter enabled: drive group again within 2P after grant falls.
// - Arbiter disabled: drive group no sooner than 2P after grant.
// - Arbiter disabled: float group, then drop request within 2P.
// - Group is byte enables, address strobe, direction and burst-last.
// - Capture control and direction selects at chip select falling edge.
// - Async reads present data together with ready going low.
// - Async mode: release data within 4P of chip select rise; ready high.
// - Sync master: release data within 4P after the relevant bus clock rise.
// - Sync master samples ready, backoff and read data at bus clock rise.
// - Sync master updates strobe, direction, burst-last, enables after bus clock rise.
// - External sync master burst-last input polarity comes from boot strap.
`timescale 1ns/100ps
module xbh_port #(
  parameter int DATA_W = xbh_pkg::DATA_W,
  parameter int BE_W = xbh_pkg::BE_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic strap_dir_pol,
  input wire logic strap_blast_pol,
  input wire logic strap_arb_en,
  input wire logic bus_input_clock,
  output logic address_strobe_line_n,
  output logic direction_line,
  input wire logic direction_select,
  output logic burst_last_line_n,
  input wire logic burst_last_line_i,
  output logic [BE_W-1:0] byte_enable_lines_o,
  input wire logic [BE_W-1:0] byte_enable_lines_i,
  output logic bus_group_oe,
  output logic [DATA_W-1:0] bus_data_lines_o,
  input wire logic [DATA_W-1:0] bus_data_lines_i,
  output logic bus_data_lines_oe,
  output logic ready_line_o,
  input wire logic ready_line_i,
  output logic ready_line_oe,
  input wire logic backoff_input_n,
  output logic wait_output,
  output logic wait_output_oe,
  output logic hold_request_o,
  input wire logic hold_request_i,
  output logic hold_request_oe,
  output logic hold_grant_o,
  input wire logic hold_grant_i,
  output logic hold_grant_oe,
  input wire logic chip_select_input_n,
  input wire logic control_select,
  input wire logic mst_req_valid,
  input wire logic mst_req_write,
  input wire logic [BE_W-1:0] mst_req_be,
  input wire logic [DATA_W-1:0] mst_req_wdata,
  input wire logic mst_wait,
  output logic mst_done,
  output logic mst_backoff,
  output logic [DATA_W-1:0] mst_rdata,
  output logic slv_req,
  output logic slv_write,
  output logic slv_cntl,
  output logic [BE_W-1:0] slv_be,
  output logic [DATA_W-1:0] slv_wdata,
  input wire logic slv_ack,
  input wire logic [DATA_W-1:0] slv_rdata,
  output logic ext_burst_last
);
  // ************************************************************
  // Input synchronisers and edge detection
  // ************************************************************
  logic [xbh_pkg::SYNC_W-1:0] sync_s;
  logic xclk_s, rdy_s, boff_s, hreq_s, hgnt_s, cs_s, cntl_s, dsel_s, blast_s;
  logic [BE_W-1:0] be_s;
  logic [DATA_W-1:0] data_s;
  logic xclk_q, cs_q;
  wire xclk_rise = xclk_s && !xclk_q;
  wire cs_fall = !cs_s && cs_q;
  wire cs_rise = cs_s && !cs_q;

  xbh_sync #(.W(xbh_pkg::SYNC_W)) u_sync (
    .clock(clock),
    .rst(rst),
    .d({bus_input_clock, ready_line_i, backoff_input_n, hold_request_i, hold_grant_i, chip_select_input_n,
        control_select, direction_select, burst_last_line_i, byte_enable_lines_i, bus_data_lines_i}),
    .q(sync_s)
  );
  assign {xclk_s, rdy_s, boff_s, hreq_s, hgnt_s, cs_s, cntl_s, dsel_s, blast_s, be_s, data_s} = sync_s;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      xclk_q <= 1'b0;
      // Matches the synchroniser's reset value, so no false select fall follows reset
      cs_q <= 1'b0;
    end
    else
    begin
      xclk_q <= xclk_s;
      cs_q <= cs_s;
    end
  end

  // ************************************************************
  // Boot straps, caught on the first edge after reset release
  // ************************************************************
  logic boot_q, dir_pol_q, blast_pol_q, arb_en_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      boot_q <= 1'b0;
      dir_pol_q <= xbh_pkg::DIR_POL_RST;
      blast_pol_q <= xbh_pkg::BLAST_POL_RST;
      arb_en_q <= xbh_pkg::ARB_EN_RST;
    end
    else if (!boot_q)
    begin
      boot_q <= 1'b1;
      dir_pol_q <= strap_dir_pol;
      blast_pol_q <= strap_blast_pol;
      arb_en_q <= strap_arb_en;
    end
  end

  assign ext_burst_last = blast_s ^ blast_pol_q;
  assign hold_grant_oe = boot_q && arb_en_q;
  assign hold_request_oe = boot_q && !arb_en_q;

  // ************************************************************
  // Bus arbitration
  // ************************************************************
  xbh_pkg::xbh_arb_t arb_q;
  logic [2:0] cnt_q;
  logic grp_oe_q, grant_q, hreq_q;
  xbh_pkg::xbh_mst_t m_q;
  wire m_idle = (m_q == xbh_pkg::M_IDLE);
  wire can_start = (arb_q == xbh_pkg::ARB_OWN) && !(arb_en_q && hreq_s);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arb_q <= xbh_pkg::ARB_BOOT;
      cnt_q <= 3'h0;
      grp_oe_q <= 1'b0;
      grant_q <= 1'b0;
      hreq_q <= 1'b0;
    end
    else
    begin
      case (arb_q)
        xbh_pkg::ARB_BOOT:
          if (boot_q)
          begin
            arb_q <= arb_en_q ? xbh_pkg::ARB_OWN : xbh_pkg::ARB_OFF;
            grp_oe_q <= arb_en_q;
          end
        xbh_pkg::ARB_OWN:
          if (arb_en_q)
          begin
            if (!hreq_s)
              cnt_q <= 3'h0;
            else if (cnt_q != 3'(xbh_pkg::FLOAT_CYC - 1))
              cnt_q <= cnt_q + 3'h1;
            else if (m_idle)
            begin
              arb_q <= xbh_pkg::ARB_FLOAT;
              grp_oe_q <= 1'b0;
              cnt_q <= 3'h0;
            end
          end
          else if (m_idle && !mst_req_valid)
          begin
            arb_q <= xbh_pkg::ARB_FLOAT;
            grp_oe_q <= 1'b0;
          end
        xbh_pkg::ARB_FLOAT:
        begin
          arb_q <= xbh_pkg::ARB_OFF;
          if (arb_en_q)
            grant_q <= 1'b1;
          else
            hreq_q <= 1'b0;
        end
        xbh_pkg::ARB_OFF:
          if (arb_en_q)
          begin
            if (hreq_s)
              cnt_q <= 3'h0;
            else if (cnt_q != 3'(xbh_pkg::DROP_CYC - 1))
              cnt_q <= cnt_q + 3'h1;
            else
            begin
              arb_q <= xbh_pkg::ARB_BACK;
              grant_q <= 1'b0;
              cnt_q <= 3'h0;
            end
          end
          else if (mst_req_valid)
          begin
            arb_q <= xbh_pkg::ARB_PEND;
            hreq_q <= 1'b1;
            cnt_q <= 3'h0;
          end
        xbh_pkg::ARB_PEND:
          if (!hgnt_s)
            cnt_q <= 3'h0;
          else if (cnt_q != 3'(xbh_pkg::DRIVE_CYC - 1))
            cnt_q <= cnt_q + 3'h1;
          else
          begin
            arb_q <= xbh_pkg::ARB_OWN;
            grp_oe_q <= 1'b1;
            cnt_q <= 3'h0;
          end
        xbh_pkg::ARB_BACK:
        begin
          arb_q <= xbh_pkg::ARB_OWN;
          grp_oe_q <= 1'b1;
        end
        default:
          arb_q <= xbh_pkg::ARB_BOOT;
      endcase
    end
  end

  assign bus_group_oe = grp_oe_q;
  assign hold_grant_o = grant_q;
  assign hold_request_o = hreq_q;

  // ************************************************************
  // Synchronous master, paced by bus clock rising edges
  // ************************************************************
  logic as_n_q, dir_q, blast_n_q, wait_q, m_write_q, m_oe_q, done_q, boff_q;
  logic [BE_W-1:0] be_q;
  logic [DATA_W-1:0] m_wdata_q, rdata_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      m_q <= xbh_pkg::M_IDLE;
      as_n_q <= 1'b1;
      dir_q <= 1'b0;
      blast_n_q <= 1'b1;
      be_q <= '0;
      wait_q <= 1'b0;
      m_write_q <= 1'b0;
      m_oe_q <= 1'b0;
      m_wdata_q <= '0;
      rdata_q <= '0;
      done_q <= 1'b0;
      boff_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      boff_q <= 1'b0;
      if (xclk_rise)
      begin
        wait_q <= mst_wait && !m_idle;
        case (m_q)
          xbh_pkg::M_IDLE:
            if (mst_req_valid && can_start)
            begin
              m_q <= xbh_pkg::M_DATA;
              as_n_q <= 1'b0;
              dir_q <= mst_req_write ^ dir_pol_q;
              blast_n_q <= 1'b0;
              be_q <= mst_req_be;
              m_write_q <= mst_req_write;
              m_oe_q <= mst_req_write;
              m_wdata_q <= mst_req_wdata;
            end
          xbh_pkg::M_DATA:
          begin
            as_n_q <= 1'b1;
            if (!boff_s || !rdy_s)
            begin
              m_q <= xbh_pkg::M_IDLE;
              blast_n_q <= 1'b1;
              m_oe_q <= 1'b0;
              done_q <= boff_s;
              boff_q <= !boff_s;
              if (boff_s && !m_write_q)
                rdata_q <= data_s;
            end
          end
          default:
            m_q <= xbh_pkg::M_IDLE;
        endcase
      end
    end
  end

  assign address_strobe_line_n = as_n_q;
  assign direction_line = dir_q;
  assign burst_last_line_n = blast_n_q;
  assign byte_enable_lines_o = be_q;
  assign wait_output = wait_q;
  assign wait_output_oe = !m_idle;
  assign mst_done = done_q;
  assign mst_backoff = boff_q;
  assign mst_rdata = rdata_q;

  // ************************************************************
  // Asynchronous slave, framed by chip select
  // ************************************************************
  xbh_pkg::xbh_slv_t s_q;
  logic sreq_q, swr_q, scntl_q, s_oe_q, rdy_drv_q;
  logic [BE_W-1:0] sbe_q;
  logic [DATA_W-1:0] sw_q, sr_q;

  // A slave access is only taken while the local master is idle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= xbh_pkg::S_IDLE;
      sreq_q <= 1'b0;
      swr_q <= 1'b0;
      scntl_q <= 1'b0;
      sbe_q <= '0;
      sw_q <= '0;
      sr_q <= '0;
      s_oe_q <= 1'b0;
      rdy_drv_q <= 1'b1;
    end
    else
    begin
      sreq_q <= 1'b0;
      case (s_q)
        xbh_pkg::S_IDLE:
          if (cs_fall && m_idle && boot_q)
          begin
            swr_q <= dsel_s ^ dir_pol_q;
            scntl_q <= cntl_s;
            sbe_q <= be_s;
            if (dsel_s ^ dir_pol_q)
            begin
              s_q <= xbh_pkg::S_WR;
              rdy_drv_q <= 1'b0;
            end
            else
            begin
              s_q <= xbh_pkg::S_RD;
              sreq_q <= 1'b1;
            end
          end
        xbh_pkg::S_RD:
          if (slv_ack)
          begin
            s_q <= xbh_pkg::S_RDY;
            sr_q <= slv_rdata;
            s_oe_q <= 1'b1;
            rdy_drv_q <= 1'b0;
          end
        xbh_pkg::S_RDY:
          if (cs_rise)
          begin
            s_q <= xbh_pkg::S_END;
            s_oe_q <= 1'b0;
            rdy_drv_q <= 1'b1;
          end
        xbh_pkg::S_WR:
          if (cs_rise)
          begin
            s_q <= xbh_pkg::S_END;
            sw_q <= data_s;
            sbe_q <= be_s;
            sreq_q <= 1'b1;
            rdy_drv_q <= 1'b1;
          end
        xbh_pkg::S_END:
          if (sreq_q || slv_ack || !swr_q)
            s_q <= xbh_pkg::S_IDLE;
        default:
          s_q <= xbh_pkg::S_IDLE;
      endcase
    end
  end

  assign slv_req = sreq_q;
  assign slv_write = swr_q;
  assign slv_cntl = scntl_q;
  assign slv_be = sbe_q;
  assign slv_wdata = sw_q;
  assign ready_line_o = rdy_drv_q;
  assign ready_line_oe = (s_q != xbh_pkg::S_IDLE);
  assign bus_data_lines_oe = m_oe_q || s_oe_q;
  assign bus_data_lines_o = s_oe_q ? sr_q : m_wdata_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_float;
    arb_en_q && $fell(grp_oe_q);
  endsequence
  sequence seq_ungrant;
    arb_en_q && $fell(grant_q);
  endsequence

  AST_BLAST_LOW: assert property ((m_q == xbh_pkg::M_DATA) |-> !blast_n_q)
    else $error("burst-last not low in data phase");
  AST_FLOAT_DELAY: assert property (seq_float |-> $past(hreq_s, 1) && $past(hreq_s, 3))
    else $error("group floated too early after hold request");
  AST_GRANT_AFTER: assert property (seq_float |-> ##[1:2] grant_q)
    else $error("grant late after float");
  AST_GRANT_KEEP: assert property (seq_ungrant |-> !$past(hreq_s, 1) && !$past(hreq_s, 3))
    else $error("grant dropped too soon");
  AST_RECLAIM: assert property (seq_ungrant |-> ##[1:2] grp_oe_q)
    else $error("group not reclaimed in time");
  AST_DIS_DRIVE: assert property (!arb_en_q && $rose(grp_oe_q) |-> $past(hgnt_s, 1) && $past(hgnt_s, 2))
    else $error("group driven too soon after grant");
  AST_DIS_DROP: assert property (!arb_en_q && $fell(grp_oe_q) |-> ##[1:2] !hreq_q)
    else $error("request not dropped after float");
  AST_RD_READY: assert property ($fell(rdy_drv_q) && !swr_q |-> s_oe_q)
    else $error("ready low without read data");
  AST_SLV_RELEASE: assert property ((s_q == xbh_pkg::S_RDY) && cs_rise |-> ##[1:4] !s_oe_q && rdy_drv_q)
    else $error("slave data not released");
  AST_MST_EDGE: assert property ($changed(as_n_q) |-> $past(xclk_rise))
    else $error("strobe changed off bus clock edge");
endmodule

// ### hdl/xbh_pkg.sv
// Shared constants for the expansion bus host port and arbitration block
package xbh_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int SYNC_W = 9 + BE_W + DATA_W;

  // ************************************************************
  // Clock periods, in ns
  // ************************************************************
  localparam int CLK_NS = 10;
  localparam int CPU_P_NS = 10;

  // ************************************************************
  // Documented times in CPU periods
  // ************************************************************
  localparam int FLOAT_MIN_P = 3;
  localparam int GRANT_MAX_P = 2;
  localparam int DROP_MIN_P = 3;
  localparam int RECLAIM_MAX_P = 2;
  localparam int DRIVE_MIN_P = 2;
  localparam int REQ_DROP_MAX_P = 2;
  localparam int DATA_HZ_MAX_P = 4;

  // ************************************************************
  // Derived cycle counts: least times round up, longest round down
  // ************************************************************
  localparam int FLOAT_CYC = (FLOAT_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int GRANT_CYC = GRANT_MAX_P * CPU_P_NS / CLK_NS;
  localparam int DROP_CYC = (DROP_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECLAIM_CYC = RECLAIM_MAX_P * CPU_P_NS / CLK_NS;
  localparam int DRIVE_CYC = (DRIVE_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int REQ_DROP_CYC = REQ_DROP_MAX_P * CPU_P_NS / CLK_NS;
  localparam int DATA_HZ_CYC = DATA_HZ_MAX_P * CPU_P_NS / CLK_NS;

  // ************************************************************
  // Reset values of the boot straps
  // ************************************************************
  localparam logic DIR_POL_RST = 1'b0;
  localparam logic BLAST_POL_RST = 1'b0;
  localparam logic ARB_EN_RST = 1'b1;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [1:0] {M_IDLE, M_DATA} xbh_mst_t;
  typedef enum logic [2:0] {S_IDLE, S_RD, S_RDY, S_WR, S_END} xbh_slv_t;
  typedef enum logic [2:0] {ARB_BOOT, ARB_OWN, ARB_PEND, ARB_FLOAT, ARB_OFF, ARB_BACK} xbh_arb_t;
endpackage

// ### hdl/xbh_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module xbh_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### tb/xbh_partner.sv
// Bus target model answering the device's synchronous master cycles
`timescale 1ns/100ps
module xbh_partner (
  input wire logic bus_input_clock,
  input wire logic address_strobe_line_n,
  input wire logic [7:0] wait_beats,
  input wire logic boff_cmd,
  input wire logic [xbh_pkg::DATA_W-1:0] rdata,
  output logic ready_line_n,
  output logic backoff_input_n,
  output logic [xbh_pkg::DATA_W-1:0] data_o
);
  int cnt = -1;

  initial
  begin
    ready_line_n = 1'b1;
    backoff_input_n = 1'b1;
    data_o = '0;
  end

  // ************************************************************
  // Answer after wait_beats bus clocks, then let go at once
  // ************************************************************
  always @(posedge bus_input_clock)
  begin
    ready_line_n <= 1'b1; // Pulled up when released, low means ready
    backoff_input_n <= 1'b1;
    data_o <= ~data_o; // Released data must never look like a held value
    if (address_strobe_line_n === 1'b0)
      cnt = int'(wait_beats);
    else if (cnt > 0)
      cnt = cnt - 1;
    if (cnt == 0)
    begin
      if (boff_cmd)
        backoff_input_n <= 1'b0;
      else
        ready_line_n <= 1'b0;
      data_o <= rdata;
      cnt = -1;
    end
  end
endmodule

// ### tb/xbh_port_bench.sv
// Self-checking bench for the expansion bus host port
`timescale 1ns/100ps
module xbh_port_bench;
  logic clock = 1'b0, rst = 1'b1, bclk = 1'b0;
  logic dpol = 1'b0, bpol = 1'b0, arb = 1'b1, boff = 1'b0, req_drv = 1'b0, gnt_drv = 1'b0, am_drv = 1'b0;
  logic dsel = 1'b0, cntl = 1'b0, cs_n = 1'b1, blast_i = 1'b0, valid = 1'b0, wr = 1'b0, mwait = 1'b0, ack = 1'b0;
  logic [3:0] be = 4'h0, be_i = 4'h0;
  logic [7:0] wt = 8'h0;
  logic [31:0] wdata = 32'h0, srd = 32'h0, am_data = 32'h0, prd = 32'h0;
  logic grp_oe, dat_oe, rdy_o, rdy_oe, wt_o, wt_oe, hr_o, hr_oe, hg_o, hg_oe, as_n, dir, bl_n, done, mboff;
  logic sreq, swr, scntl, ebl, p_rdy, p_boff;
  logic [3:0] be_o, sbe;
  logic [31:0] d_o, mrd, swd, p_d;
  int failures = 0, compares = 0, cycles = 0;

  initial
  begin
    forever #5 clock = ~clock;
  end
  initial
  begin
    #3;
    forever #40 bclk = ~bclk;
  end

  xbh_port i_xbh_port (.clock(clock), .rst(rst), .strap_dir_pol(dpol), .strap_blast_pol(bpol),
    .strap_arb_en(arb), .bus_input_clock(bclk), .address_strobe_line_n(as_n), .direction_line(dir),
    .direction_select(dsel), .burst_last_line_n(bl_n), .burst_last_line_i(blast_i),
    .byte_enable_lines_o(be_o), .byte_enable_lines_i(be_i), .bus_group_oe(grp_oe),
    .bus_data_lines_o(d_o), .bus_data_lines_i(dat_oe ? d_o : (am_drv ? am_data : p_d)),
    .bus_data_lines_oe(dat_oe), .ready_line_o(rdy_o), .ready_line_i(rdy_oe ? rdy_o : p_rdy),
    .ready_line_oe(rdy_oe), .backoff_input_n(p_boff), .wait_output(wt_o), .wait_output_oe(wt_oe),
    .hold_request_o(hr_o), .hold_request_i(hr_oe ? hr_o : req_drv), .hold_request_oe(hr_oe),
    .hold_grant_o(hg_o), .hold_grant_i(hg_oe ? hg_o : gnt_drv), .hold_grant_oe(hg_oe),
    .chip_select_input_n(cs_n), .control_select(cntl), .mst_req_valid(valid), .mst_req_write(wr),
    .mst_req_be(be), .mst_req_wdata(wdata), .mst_wait(mwait), .mst_done(done), .mst_backoff(mboff),
    .mst_rdata(mrd), .slv_req(sreq), .slv_write(swr), .slv_cntl(scntl), .slv_be(sbe),
    .slv_wdata(swd), .slv_ack(ack), .slv_rdata(srd), .ext_burst_last(ebl));

  xbh_partner i_xbh_partner (.bus_input_clock(bclk), .address_strobe_line_n(as_n), .wait_beats(wt),
    .boff_cmd(boff), .rdata(prd), .ready_line_n(p_rdy), .backoff_input_n(p_boff), .data_o(p_d));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic boot(input logic dp, input logic bp, input logic ae);
    @(negedge clock);
    rst = 1'b1;
    dpol = dp;
    bpol = bp;
    arb = ae;
    blast_i = 1'b1;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check(grp_oe, ae); // Bus owned only with the arbiter enabled
    check(ebl, 1'b1 ^ bp);
    $display("boot done");
  endtask

  // Master beat; hreq raises a hold request in mid-transfer
  task automatic mst_xfer(input logic w, input logic [3:0] b, input logic [7:0] beats, input logic bo,
                          input logic hreq);
    int n;
    logic early;
    early = 1'b0;
    wt = beats;
    boff = bo;
    wr = w;
    be = b;
    wdata = 32'h1234_abcd;
    prd = 32'h5e5e_0770;
    mwait = 1'b1;
    valid = 1'b1;
    for (n = 0; n < 200 && as_n !== 1'b0; n++) @(negedge clock);
    check(dir, w ^ dpol);
    check(bl_n, 1'b0);
    check(be_o, b);
    check(grp_oe, 1'b1);
    check(dat_oe, w);
    check(wt_oe, 1'b1);
    if (w)
      check(d_o, 32'h1234_abcd);
    req_drv = hreq;
    for (n = 0; n < 900 && done !== 1'b1 && mboff !== 1'b1; n++)
    begin
      if (hg_oe === 1'b1 && hg_o === 1'b1)
        early = 1'b1;
      @(negedge clock);
    end
    valid = 1'b0;
    mwait = 1'b0;
    check(early, 1'b0);
    check(mboff, bo);
    check(wt_o, 1'b1);
    check(wt_oe, 1'b0);
    check(dat_oe, 1'b0);
    if (!w && !bo)
      check(mrd, 32'h5e5e_0770);
    if (hreq)
    begin
      for (n = 0; n < 20 && hg_o !== 1'b1; n++) @(negedge clock);
      check(hg_o, 1'b1); // Grant follows the finished beat
      @(negedge clock);
      req_drv = 1'b0;
      for (n = 0; n < 50 && grp_oe !== 1'b1; n++) @(negedge clock);
      check(grp_oe, 1'b1);
    end
    repeat (2) @(negedge clock);
    $display("master beat done");
  endtask

  task automatic arb_on();
    int n;
    req_drv = 1'b1;
    for (n = 0; n < 50 && grp_oe !== 1'b0; n++) @(negedge clock);
    check(n >= 3, 1'b1);
    for (n = 0; n < 10 && hg_o !== 1'b1; n++) @(negedge clock);
    check(n <= 2, 1'b1);
    @(negedge clock);
    req_drv = 1'b0; // Held a full period past the grant
    for (n = 0; n < 50 && hg_o !== 1'b0; n++) @(negedge clock);
    check(n >= 3, 1'b1);
    for (n = 0; n < 10 && grp_oe !== 1'b1; n++) @(negedge clock);
    check(n <= 2, 1'b1);
    $display("arbiter enabled done");
  endtask

  task automatic arb_off();
    int n;
    valid = 1'b1;
    for (n = 0; n < 200 && hr_o !== 1'b1; n++) @(negedge clock);
    check(hr_oe, 1'b1);
    gnt_drv = 1'b1;
    for (n = 0; n < 50 && grp_oe !== 1'b1; n++) @(negedge clock);
    check(n >= 2, 1'b1);
    mst_xfer(1'b0, 4'hc, 8'h0, 1'b0, 1'b0);
    for (n = 0; n < 200 && grp_oe !== 1'b0; n++) @(negedge clock);
    for (n = 0; n < 10 && hr_o !== 1'b0; n++) @(negedge clock);
    check(n <= 2, 1'b1);
    gnt_drv = 1'b0;
    $display("arbiter disabled done");
  endtask

  task automatic async_acc(input logic w);
    int n;
    cntl = 1'b1;
    dsel = w ^ dpol;
    be_i = 4'h9;
    am_data = 32'h0f0f_5a5a;
    am_drv = w;
    @(negedge clock);
    cs_n = 1'b0;
    if (!w)
    begin
      for (n = 0; n < 20 && sreq !== 1'b1; n++) @(negedge clock);
      check(swr, 1'b0);
      check(scntl, 1'b1);
      srd = 32'hc3c3_1234;
      ack = 1'b1;
      @(negedge clock);
      ack = 1'b0;
    end
    for (n = 0; n < 20 && rdy_o !== 1'b0; n++) @(negedge clock);
    check(rdy_oe, 1'b1);
    check(dat_oe, !w);
    if (!w)
      check(d_o, 32'hc3c3_1234);
    repeat (4) @(negedge clock); // Select held low 4P past ready
    cs_n = 1'b1;
    if (w)
    begin
      for (n = 0; n < 20 && sreq !== 1'b1; n++) @(negedge clock);
      check({swr, sbe}, 5'h19);
      check(swd, 32'h0f0f_5a5a);
    end
    else
    begin
      repeat (4) @(negedge clock);
      check(dat_oe, 1'b0);
      check(rdy_oe ? rdy_o : 1'b1, 1'b1);
    end
    am_drv = 1'b0;
    repeat (5) @(negedge clock); // Select high at least 5P between accesses
    $display("async access done");
  endtask

  initial
  begin
    boot(1'b0, 1'b0, 1'b1);
    mst_xfer(1'b1, 4'h5, 8'h0, 1'b0, 1'b0);
    mst_xfer(1'b0, 4'ha, 8'h2, 1'b0, 1'b0);
    mst_xfer(1'b1, 4'hf, 8'h1, 1'b1, 1'b0);
    async_acc(1'b0);
    async_acc(1'b1);
    mst_xfer(1'b1, 4'h3, 8'h3, 1'b0, 1'b1);
    arb_on();
    boot(1'b1, 1'b1, 1'b0);
    arb_off();
    async_acc(1'b0);
    test_done();
  end
endmodule
